// ---- acs_pkg.sv ----
// Package for the conversion sequencer: register map, fields, timing.
package acs_pkg;

	// ********************************
	// Register byte addresses
	// ********************************
	localparam logic [7:0] ADDR_RESULT_HIGH = 8'h00;
	localparam logic [7:0] ADDR_RESULT_LOW = 8'h04;
	localparam logic [7:0] ADDR_CHANNEL_CONTROL = 8'h08;
	localparam logic [7:0] ADDR_FORMAT_CONFIG = 8'h0c;
	localparam logic [7:0] ADDR_COMPARE_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_PORT_DATA = 8'h14;
	localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h18;
	localparam logic [7:0] ADDR_STATUS = 8'h1c;

	// ********************************
	// Fields and reset values
	// ********************************
	localparam int CC_ENABLE_BIT = 0;
	localparam int CC_START_BIT = 2;
	localparam int CC_CHAN_LSB = 3;
	localparam int CC_CLKSEL_LSB = 6;
	localparam int FC_PCFG_LSB = 0;
	localparam int FC_CLKSEL2_BIT = 6;
	localparam int FC_FORMAT_BIT = 7;
	localparam logic [7:0] CC_WRITE_MASK = 8'hfd;
	localparam logic [7:0] FC_WRITE_MASK = 8'hcf;
	localparam logic [7:0] CC_RESET = 8'h00;
	localparam logic [7:0] FC_RESET = 8'h00;
	localparam logic [3:0] TRIGGER_MODE = 4'hb;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ********************************
	// Conversion clock selections
	// ********************************
	localparam logic [2:0] CLKSEL_DIV2 = 3'h0;
	localparam logic [2:0] CLKSEL_DIV4 = 3'h4;
	localparam logic [2:0] CLKSEL_DIV8 = 3'h1;
	localparam logic [2:0] CLKSEL_DIV16 = 3'h5;
	localparam logic [2:0] CLKSEL_DIV32 = 3'h2;
	localparam logic [2:0] CLKSEL_DIV64 = 3'h6;

	// ********************************
	// Timing in conversion clock periods
	// ********************************
	localparam logic [3:0] CONVERT_PERIODS = 4'd12;
	localparam logic [3:0] ABORT_WAIT_PERIODS = 4'd2;

	typedef enum {ST_IDLE, ST_CONVERT, ST_HOLDOFF} acs_state_t;

	typedef struct packed {
		logic [9:0] value;
		logic done;
	} acs_core_result_t;

endpackage

// ---- acs_sequencer.sv ----
// Conversion sequencer with AXI4-Lite register slave.
`timescale 1ns/100ps
module acs_sequencer import acs_pkg::*; #(
	parameter int PIN_COUNT = 8
) (
	input wire logic aclk, // System clock, 50 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read valid
	input wire logic s_axi_rready, // Read ready
	input wire logic rc_clock_tick, // Internal RC clock level, async
	input wire logic special_event_trigger, // Compare trigger pulse, same clock
	input wire logic [PIN_COUNT-1:0] pin_level, // Raw pin levels, async
	input wire logic [PIN_COUNT-1:0] analog_pin_map, // Pins set analog by config decode
	input wire acs_core_result_t core_result, // Core result and done pulse
	output logic core_start, // Start pulse to analog core
	output logic core_abort, // Abort pulse to analog core
	output logic core_acquire, // Acquisition restart pulse
	output logic [2:0] core_channel, // Selected channel
	output logic [3:0] analog_pin_config, // Analog pin configuration field
	output logic conversion_tick, // One tick per conversion period
	output logic timer_reset, // Clears Timer1 or Timer3
	output logic converter_interrupt_flag // Set on completion, cleared on write
);

	// ********************************
	// Registers
	// ********************************
	logic [7:0] channel_control;
	logic [7:0] format_config;
	logic [7:0] compare_control;
	logic [7:0] pin_direction;
	logic [7:0] result_high;
	logic [7:0] result_low;
	acs_state_t state;
	logic [6:0] div_count;
	logic [3:0] period_count;
	logic [1:0] rc_sync;
	logic rc_prev;
	logic [PIN_COUNT-1:0] pin_meta;
	logic [PIN_COUNT-1:0] pin_sync;
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	wire converter_enable_bit = channel_control[CC_ENABLE_BIT];
	wire start_done = channel_control[CC_START_BIT];
	wire result_format_select = format_config[FC_FORMAT_BIT];
	wire [2:0] conversion_clock_select = {format_config[FC_CLKSEL2_BIT],
		channel_control[CC_CLKSEL_LSB+1:CC_CLKSEL_LSB]};
	wire [3:0] compare_mode_field = compare_control[3:0];

	// Divider length for a selection; zero means internal RC
	function automatic logic [6:0] div_len(input logic [2:0] sel);
		case (sel)
			CLKSEL_DIV2: div_len = 7'd2;
			CLKSEL_DIV4: div_len = 7'd4;
			CLKSEL_DIV8: div_len = 7'd8;
			CLKSEL_DIV16: div_len = 7'd16;
			CLKSEL_DIV32: div_len = 7'd32;
			CLKSEL_DIV64: div_len = 7'd64;
			default: div_len = 7'd0;
		endcase
	endfunction

	// ********************************
	// Conversion clock
	// ********************************
	// RC clock synchronised
	always_ff @(posedge aclk) begin
		rc_sync <= {rc_sync[0], rc_clock_tick};
		rc_prev <= rc_sync[1];
	end

	wire [6:0] cur_len = div_len(conversion_clock_select);

	// tick from divider or RC rising edge
	always_comb begin
		if (cur_len == 7'd0) begin
			conversion_tick = state != ST_IDLE && rc_sync[1] && !rc_prev;
		end else begin
			conversion_tick = state != ST_IDLE && div_count == cur_len - 7'd1;
		end
	end

	// ********************************
	// Register write decode
	// ********************************
	wire wr_fire = aw_held && w_held && !s_axi_bvalid;
	wire wr_byte = wr_fire && w_strb[0];
	wire [7:0] wr_val = w_data[7:0];
	wire wr_cc = wr_byte && aw_addr == ADDR_CHANNEL_CONTROL;
	wire soft_start = wr_cc && wr_val[CC_START_BIT] && !start_done;
	wire soft_clear = wr_cc && !wr_val[CC_START_BIT];
	// trigger starts only in mode 1011 with converter enabled
	wire trig_start = special_event_trigger && compare_mode_field == TRIGGER_MODE
		&& converter_enable_bit;
	wire abort_now = state == ST_CONVERT && (soft_clear || !converter_enable_bit);
	// Abort in the last period wins, so no partial result lands
	wire finish = state == ST_CONVERT && conversion_tick
		&& period_count == CONVERT_PERIODS - 4'd1 && !abort_now;

	// Restart on abort, so with a divider selected the holdoff spans two whole periods
	// divider counter
	always_ff @(posedge aclk) begin
		if (!aresetn || state == ST_IDLE || cur_len == 7'd0 || abort_now) begin
			div_count <= 7'd0;
		end else if (div_count >= cur_len - 7'd1) begin
			div_count <= 7'd0;
		end else begin
			div_count <= div_count + 7'd1;
		end
	end

	// ********************************
	// Sequencer
	// ********************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			period_count <= 4'd0;
		end else begin
			case (state)
				ST_IDLE: begin
					period_count <= 4'd0;
					if (start_done && converter_enable_bit) begin
						state <= ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					if (abort_now) begin
						state <= ST_HOLDOFF;
						period_count <= 4'd0;
					end else if (finish) begin
						state <= ST_IDLE;
					end else if (conversion_tick) begin
						period_count <= period_count + 4'd1;
					end
				end
				ST_HOLDOFF: begin
					if (conversion_tick) begin
						if (period_count == ABORT_WAIT_PERIODS - 4'd1) begin
							state <= ST_IDLE;
						end else begin
							period_count <= period_count + 4'd1;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_comb begin
		core_start = state == ST_IDLE && start_done && converter_enable_bit;
		core_abort = abort_now;
		core_acquire = state == ST_HOLDOFF && conversion_tick
			&& period_count == ABORT_WAIT_PERIODS - 4'd1;
		core_channel = channel_control[CC_CHAN_LSB+2:CC_CHAN_LSB];
		analog_pin_config = format_config[FC_PCFG_LSB+3:FC_PCFG_LSB];
		// a trigger in mode 1011 resets the timer, even when disabled
		timer_reset = special_event_trigger && compare_mode_field == TRIGGER_MODE;
	end

	// ********************************
	// Control registers
	// ********************************
	// reset returns control registers to reset state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_control <= CC_RESET;
			format_config <= FC_RESET;
			compare_control <= 8'h00;
			pin_direction <= 8'hff;
		end else begin
			if (wr_cc) begin
				channel_control <= (wr_val & CC_WRITE_MASK) | {5'h00, start_done, 2'b00}
					& {5'h00, wr_val[CC_START_BIT], 2'b00};
				// Software start only sets; a clear write clears
				if (soft_start) begin
					channel_control[CC_START_BIT] <= 1'b1;
				end
			end
			if (wr_byte && aw_addr == ADDR_FORMAT_CONFIG) begin
				format_config <= wr_val & FC_WRITE_MASK;
			end
			if (wr_byte && aw_addr == ADDR_COMPARE_CONTROL) begin
				compare_control <= wr_val;
			end
			if (wr_byte && aw_addr == ADDR_PIN_DIRECTION) begin
				pin_direction <= wr_val;
			end
			// done clears start bit; trigger set wins
			if (trig_start) begin
				channel_control[CC_START_BIT] <= 1'b1;
			end else if (finish || (state == ST_CONVERT && !converter_enable_bit)) begin
				channel_control[CC_START_BIT] <= 1'b0;
			end
		end
	end

	// flag set with completion; set wins over clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			converter_interrupt_flag <= 1'b0;
		end else if (finish) begin
			converter_interrupt_flag <= 1'b1;
		end else if (wr_byte && aw_addr == ADDR_STATUS && wr_val[0]) begin
			converter_interrupt_flag <= 1'b0;
		end
	end

	// ********************************
	// Result pair, kept through reset
	// ********************************
	// no reset on the result bytes
	always_ff @(posedge aclk) begin
		// load on completion, never on abort
		if (finish) begin
			if (result_format_select) begin
				result_high <= {6'h00, core_result.value[9:8]};
				result_low <= core_result.value[7:0];
			end else begin
				result_high <= core_result.value[9:2];
				result_low <= {core_result.value[1:0], 6'h00};
			end
		end else begin
			// plain registers when no result lands
			if (wr_byte && aw_addr == ADDR_RESULT_HIGH) begin
				result_high <= wr_val;
			end
			if (wr_byte && aw_addr == ADDR_RESULT_LOW) begin
				result_low <= wr_val;
			end
		end
	end

	// ********************************
	// Pins
	// ********************************
	always_ff @(posedge aclk) begin
		pin_meta <= pin_level;
		pin_sync <= pin_meta;
	end

	// ********************************
	// AXI4-Lite write channel
	// ********************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_bvalid <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0;
			w_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	function automatic logic mapped(input logic [7:0] a);
		mapped = a[1:0] == 2'b00 && a <= ADDR_STATUS;
	endfunction

	logic wr_ok;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_ok <= 1'b1;
		end else if (wr_fire) begin
			wr_ok <= mapped(aw_addr) && aw_addr != ADDR_PORT_DATA;
		end
	end

	always_comb begin
		s_axi_awready = !aw_held && !s_axi_bvalid;
		s_axi_wready = !w_held && !s_axi_bvalid;
		s_axi_bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
	end

	// ********************************
	// AXI4-Lite read channel
	// ********************************
	logic [7:0] rd_val;
	always_comb begin
		case (s_axi_araddr)
			ADDR_RESULT_HIGH: rd_val = result_high;
			ADDR_RESULT_LOW: rd_val = result_low;
			ADDR_CHANNEL_CONTROL: rd_val = channel_control;
			ADDR_FORMAT_CONFIG: rd_val = format_config;
			ADDR_COMPARE_CONTROL: rd_val = compare_control;
			ADDR_PORT_DATA: rd_val = 8'(pin_sync & ~analog_pin_map);
			ADDR_PIN_DIRECTION: rd_val = pin_direction;
			ADDR_STATUS: rd_val = {6'h00, state != ST_IDLE, converter_interrupt_flag};
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h0, rd_val};
			s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	// ********************************
	// Assertions
	// ********************************
	sequence conv_done_s;
		finish;
	endsequence

	result_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
		conv_done_s ##1 1 |-> (result_format_select ? result_high[7:2] == 6'h00
			: result_low[5:0] == 6'h00)) else $error("result fill not zero");
	abort_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
		abort_now |=> $stable(result_high) && $stable(result_low))
		else $error("abort changed result");
	done_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		finish && !trig_start |=> !start_done && converter_interrupt_flag)
		else $error("completion did not clear start and set flag");
	abort_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		abort_now |=> state == ST_HOLDOFF) else $error("abort did not hold off");
	trig_timer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		special_event_trigger && compare_mode_field == TRIGGER_MODE |-> timer_reset)
		else $error("trigger did not reset timer");
	trig_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		special_event_trigger && !converter_enable_bit && !start_done && !wr_fire
		|=> !start_done) else $error("disabled trigger set start");
	trig_start_a: assert property (@(posedge aclk) disable iff (!aresetn)
		trig_start |=> start_done) else $error("trigger did not set start");
	port_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_PORT_DATA
		|=> (s_axi_rdata[PIN_COUNT-1:0] & $past(analog_pin_map)) == '0)
		else $error("analog pin read nonzero");
	div2_tick_a: assert property (@(posedge aclk) disable iff (!aresetn)
		state == ST_CONVERT && conversion_tick && conversion_clock_select == CLKSEL_DIV2
		&& $stable(conversion_clock_select) ##1 state == ST_CONVERT |=> conversion_tick)
		else $error("divide by two tick spacing wrong");

endmodule

// ---- acs_core_model.sv ----
// Behavioural model of the analog converter core and channel multiplexer.
`timescale 1ns/100ps
module acs_core_model import acs_pkg::*; (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic core_start, // Start request
	input wire logic core_abort, // Abort request
	input wire logic [2:0] core_channel, // Selected channel
	input wire logic conversion_tick, // One tick per conversion period
	output acs_core_result_t core_result // Sample value and done pulse
);
	logic busy;
	logic [3:0] ticks;
	logic [9:0] sample;
	logic [9:0] idle_pat;

	// Sample is latched at start, so a later channel change cannot alter it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			ticks <= 4'h0;
		end else if (core_abort) begin
			busy <= 1'b0;
		end else if (core_start && !busy) begin
			busy <= 1'b1;
			ticks <= 4'h0;
			sample <= {core_channel, 7'h2b} ^ 10'h155;
		end else if (busy && conversion_tick) begin
			ticks <= ticks + 4'h1;
			if (ticks == 4'hb) begin
				busy <= 1'b0;
			end
		end
	end

	// Outside a conversion the value toggles, so a stale sample never looks valid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_pat <= 10'h2aa;
		end else begin
			idle_pat <= ~idle_pat;
		end
	end

	assign core_result.value = busy ? sample : idle_pat;
	assign core_result.done = busy && conversion_tick && (ticks == 4'hb);
endmodule

// ---- tb.sv ----
// Self-checking testbench for the conversion sequencer.
`timescale 1ns/100ps
module tb import acs_pkg::*;;
	localparam logic [2:0] CODES [7] = '{CLKSEL_DIV2, CLKSEL_DIV4, CLKSEL_DIV8, CLKSEL_DIV16,
		CLKSEL_DIV32, CLKSEL_DIV64, 3'h3};
	localparam int DIVS [7] = '{2, 4, 8, 16, 32, 64, 10};
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic rc_clock_tick, special_event_trigger, core_start, core_abort, core_acquire;
	logic conversion_tick, timer_reset, converter_interrupt_flag;
	logic [7:0] s_axi_awaddr, s_axi_araddr, pin_level, analog_pin_map, last_hi, last_lo;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] core_channel;
	logic [3:0] analog_pin_config;
	acs_core_result_t core_result;
	logic [33:0] rd_q[$];
	int failures, tests_run, rc_cnt, i;

	acs_sequencer #(.PIN_COUNT(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rc_clock_tick(rc_clock_tick),
		.special_event_trigger(special_event_trigger), .pin_level(pin_level),
		.analog_pin_map(analog_pin_map), .core_result(core_result), .core_start(core_start),
		.core_abort(core_abort), .core_acquire(core_acquire), .core_channel(core_channel),
		.analog_pin_config(analog_pin_config), .conversion_tick(conversion_tick),
		.timer_reset(timer_reset),
		.converter_interrupt_flag(converter_interrupt_flag));
	acs_core_model i_core (.aclk(aclk), .aresetn(aresetn), .core_start(core_start),
		.core_abort(core_abort), .core_channel(core_channel), .conversion_tick(conversion_tick),
		.core_result(core_result));

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// Internal RC clock: one rising edge every 10 system cycles
	always @(posedge aclk) begin
		rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
		if (rc_cnt == 4) begin
			rc_clock_tick <= ~rc_clock_tick;
		end
	end

	// ********************************
	// Checking
	// ********************************
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Read results are matched against the oldest note
	always @(negedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			if (rd_q.size() == 0) begin
				check_val(32'h1, 32'h0, "read without note");
			end else begin
				check_val(s_axi_rdata, {24'h0, rd_q[0][7:0]}, "read data");
				check_val({30'h0, s_axi_rresp}, {30'h0, rd_q[0][33:32]}, "read resp");
				void'(rd_q.pop_front());
			end
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge aclk);
		failures++;
		$display("wrong value at %0t: watchdog expired", $time);
		give_verdict();
	end

	// ********************************
	// Bus and sequence tasks
	// ********************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic ah, wh, bh;
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		bh = 1'b0;
		n = 0;
		while (!bh && n < 200) begin
			@(negedge aclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid && s_axi_bready;
			if (bh) check_val({30'h0, s_axi_bresp}, {30'h0, er}, "write resp");
			@(posedge aclk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		if (!bh) check_val(32'h0, 32'h1, "write answer");
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic ah, rh;
		int n;
		@(posedge aclk);
		rd_q.push_back({er, 24'h0, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		rh = 1'b0;
		n = 0;
		while (!rh && n < 200) begin
			@(negedge aclk);
			ah = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid && s_axi_rready;
			@(posedge aclk);
			if (ah) s_axi_arvalid <= 1'b0;
			n++;
		end
		s_axi_rready <= 1'b0;
		if (!rh) check_val(32'h0, 32'h1, "read answer");
	endtask

	// Counts ticks from the first to the twelfth; flag rises right after
	task automatic wait_done(input int div);
		int n, ticks, first, last;
		n = 0;
		ticks = 0;
		while (converter_interrupt_flag !== 1'b1 && n < 3000) begin
			@(negedge aclk);
			if (conversion_tick === 1'b1) begin
				if (ticks == 0) first = n;
				last = n;
				ticks++;
			end
			n++;
		end
		check_val(ticks, 12, "period count");
		check_val(last - first, 11 * div, "period length");
	endtask

	task automatic set_result(input logic [2:0] ch, input logic fmt);
		logic [9:0] v;
		v = {ch, 7'h2b} ^ 10'h155;
		last_hi = fmt ? {6'h0, v[9:8]} : v[9:2];
		last_lo = fmt ? v[7:0] : {v[1:0], 6'h0};
	endtask

	task automatic run_conv(input logic [2:0] code, input int div, input logic fmt, input logic [2:0] ch);
		logic [7:0] cc;
		cc = {code[1:0], ch, 3'b001};
		set_result(ch, fmt);
		wr(ADDR_FORMAT_CONFIG, {fmt, code[2], 3'h0, ch}, RESP_OKAY);
		check_val({28'h0, analog_pin_config}, {29'h0, ch}, "pin config");
		wr(ADDR_CHANNEL_CONTROL, cc, RESP_OKAY);
		fork
			begin
				wr(ADDR_CHANNEL_CONTROL, cc | 8'h04, RESP_OKAY);
				seed = xs(seed);
				wr(ADDR_PIN_DIRECTION, seed[7:0], RESP_OKAY);
				wr(ADDR_CHANNEL_CONTROL, cc ^ 8'h2c, RESP_OKAY);
			end
			wait_done(div);
		join
		rd(ADDR_RESULT_HIGH, last_hi, RESP_OKAY);
		rd(ADDR_RESULT_LOW, last_lo, RESP_OKAY);
		rd(ADDR_CHANNEL_CONTROL, cc ^ 8'h28, RESP_OKAY);
		wr(ADDR_STATUS, 8'h01, RESP_OKAY);
		check_val({31'h0, converter_interrupt_flag}, 32'h0, "flag clear");
		rd(ADDR_STATUS, 8'h00, RESP_OKAY);
		$display("test conversion with select %0d done", code);
	endtask

	task automatic abort_test();
		logic [7:0] cc;
		logic ab, aq, fl;
		int n, t, na;
		cc = {CLKSEL_DIV64[1:0], 3'h2, 3'b001};
		wr(ADDR_FORMAT_CONFIG, {1'b1, CLKSEL_DIV64[2], 6'h0}, RESP_OKAY);
		wr(ADDR_CHANNEL_CONTROL, cc, RESP_OKAY);
		fork
			begin
				wr(ADDR_CHANNEL_CONTROL, cc | 8'h04, RESP_OKAY);
				repeat (200) @(posedge aclk);
				wr(ADDR_CHANNEL_CONTROL, cc, RESP_OKAY);
			end
			begin
				ab = 1'b0;
				aq = 1'b0;
				fl = 1'b0;
				t = 0;
				n = 0;
				na = 0;
				while (!aq && n < 3000) begin
					@(negedge aclk);
					if (core_abort === 1'b1) begin
						ab = 1'b1;
						na = n;
					end else if (ab && conversion_tick === 1'b1) begin
						t++;
					end
					aq = (core_acquire === 1'b1);
					fl = fl | converter_interrupt_flag;
					n++;
				end
				check_val({31'h0, ab}, 32'h1, "abort pulse");
				check_val(t, 2, "holdoff periods");
				check_val(n - 1 - na, ABORT_WAIT_PERIODS * DIVS[5], "holdoff length");
				check_val({31'h0, fl}, 32'h0, "flag after abort");
			end
		join
		rd(ADDR_RESULT_HIGH, last_hi, RESP_OKAY);
		rd(ADDR_RESULT_LOW, last_lo, RESP_OKAY);
		rd(ADDR_CHANNEL_CONTROL, cc, RESP_OKAY);
		$display("test abort done");
	endtask

	task automatic trig(input logic [3:0] mode, input logic en, input logic hit);
		logic [7:0] cc;
		cc = {CLKSEL_DIV2[1:0], 3'h3, 2'b00, en};
		wr(ADDR_COMPARE_CONTROL, {4'h0, mode}, RESP_OKAY);
		wr(ADDR_FORMAT_CONFIG, 8'h80, RESP_OKAY);
		wr(ADDR_CHANNEL_CONTROL, cc, RESP_OKAY);
		@(posedge aclk);
		special_event_trigger <= 1'b1;
		@(negedge aclk);
		check_val({31'h0, timer_reset}, {31'h0, hit}, "timer reset");
		@(posedge aclk);
		special_event_trigger <= 1'b0;
		if (en && hit) begin
			wait_done(2);
			set_result(3'h3, 1'b1);
			rd(ADDR_RESULT_LOW, last_lo, RESP_OKAY);
			wr(ADDR_STATUS, 8'h01, RESP_OKAY);
		end else begin
			repeat (4) @(posedge aclk);
			rd(ADDR_CHANNEL_CONTROL, cc, RESP_OKAY);
		end
		$display("test trigger mode %0h enable %0d done", mode, en);
	endtask

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{rc_clock_tick, special_event_trigger, aresetn} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, pin_level, analog_pin_map} = 32'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h1;
		seed = 32'h600c;
		{failures, tests_run, rc_cnt} = 96'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_CHANNEL_CONTROL, CC_RESET, RESP_OKAY);
		rd(ADDR_FORMAT_CONFIG, FC_RESET, RESP_OKAY);
		rd(8'h20, 8'h00, RESP_SLVERR);
		wr(ADDR_PORT_DATA, 8'h55, RESP_SLVERR);
		seed = xs(seed);
		last_hi = seed[7:0];
		last_lo = seed[15:8];
		wr(ADDR_RESULT_HIGH, last_hi, RESP_OKAY);
		wr(ADDR_RESULT_LOW, last_lo, RESP_OKAY);
		s_axi_wstrb <= 4'h0;
		wr(ADDR_RESULT_HIGH, ~last_hi, RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(ADDR_RESULT_HIGH, last_hi, RESP_OKAY);
		rd(ADDR_RESULT_LOW, last_lo, RESP_OKAY);
		$display("test reset and plain registers done");
		for (i = 0; i < 3; i++) begin
			seed = xs(seed);
			pin_level <= seed[7:0];
			analog_pin_map <= seed[15:8];
			repeat (4) @(posedge aclk);
			rd(ADDR_PORT_DATA, seed[7:0] & ~seed[15:8], RESP_OKAY);
		end
		$display("test port read-back done");
		for (i = 0; i < 7; i++) begin
			run_conv(CODES[i], DIVS[i], i[0], i[2:0]);
		end
		abort_test();
		trig(TRIGGER_MODE, 1'b0, 1'b1);
		trig(4'ha, 1'b1, 1'b0);
		trig(TRIGGER_MODE, 1'b1, 1'b1);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(ADDR_RESULT_LOW, last_lo, RESP_OKAY);
		rd(ADDR_CHANNEL_CONTROL, CC_RESET, RESP_OKAY);
		$display("test second reset done");
		give_verdict();
	end
endmodule
